// ==== hdl/lsm_pkg.sv ====
`default_nettype none
package lsm_pkg;

    // ==========================================================
    // operation codes
    typedef enum logic [2:0] {
        LSM_OP_NONE = 3'b000,  // idle
        LSM_OP_OR   = 3'b001,  // or_accumulator_with_file
        LSM_OP_LSL  = 3'b010,  // logical_shift_left_file
        LSM_OP_LSR  = 3'b011,  // logical_shift_right_file
        LSM_OP_MOV  = 3'b100,  // move_file_register
        LSM_OP_IND  = 3'b101,  // indirect_load_to_accumulator, update code form
        LSM_OP_REL  = 3'b110   // indirect_load_to_accumulator, relative offset form
    } lsm_op_t;

    // ==========================================================
    // pointer update codes
    localparam logic [1:0] LSM_UPD_PRE_INC  = 2'h0;
    localparam logic [1:0] LSM_UPD_PRE_DEC  = 2'h1;
    localparam logic [1:0] LSM_UPD_POST_INC = 2'h2;
    localparam logic [1:0] LSM_UPD_POST_DEC = 2'h3;

    // ==========================================================
    // widths, reset values, file addresses
    localparam int          LSM_DW          = 8;
    localparam int          LSM_AW          = 16;
    localparam logic [6:0]  LSM_FADDR_IND0  = 7'h00;   // indirect_access_port 0
    localparam logic [6:0]  LSM_FADDR_IND1  = 7'h01;   // indirect_access_port 1
    localparam logic [7:0]  LSM_ACC_RST     = 8'h00;
    localparam logic [15:0] LSM_PTR_RST     = 16'h0000;
    localparam logic [15:0] LSM_PTR_STEP    = 16'h0001;

    // ==========================================================
    // instruction as issued by the core
    typedef struct packed {
        lsm_op_t    op;      // operation
        logic       dest;    // 0 accumulator, 1 file register
        logic [6:0] faddr;   // file address
        logic       psel;    // pointer index
        logic [1:0] upd;     // pointer_update_code
        logic [5:0] offs;    // signed relative offset
    } lsm_instr_t;

    // data-memory request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } lsm_mem_req_t;

    // status flags
    typedef struct packed {
        logic carry;
        logic zero;
    } lsm_flags_t;

endpackage
`default_nettype wire

// ==== hdl/lsm_ptr_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pointer adjust: effective address and next pointer value
module lsm_ptr_unit
    import lsm_pkg::*;
(
    input  wire logic [15:0] ptr,       // current pointer
    input  wire logic        rel,       // relative offset form
    input  wire logic [1:0]  upd,       // pointer_update_code
    input  wire logic [5:0]  offs,      // signed offset
    output logic      [15:0] eff_addr,  // address used for the access
    output logic      [15:0] ptr_next   // pointer after the access
);
    logic [15:0] inc;   // wraps FFFF->0000 by width
    logic [15:0] dec;   // wraps 0000->FFFF by width
    logic [15:0] sext;  // sign-extended offset

    always_comb begin
        inc  = ptr + LSM_PTR_STEP;                  // RULE_10
        dec  = ptr - LSM_PTR_STEP;                  // RULE_10
        sext = {{10{offs[5]}}, offs};
        if (rel) begin
            eff_addr = ptr + sext;                  // RULE_08
            ptr_next = ptr;                         // RULE_08
        end else begin
            unique case (upd)                       // RULE_07
                LSM_UPD_PRE_INC: begin
                    eff_addr = inc;
                    ptr_next = inc;
                end
                LSM_UPD_PRE_DEC: begin
                    eff_addr = dec;
                    ptr_next = dec;
                end
                LSM_UPD_POST_INC: begin
                    eff_addr = ptr;
                    ptr_next = inc;
                end
                LSM_UPD_POST_DEC: begin
                    eff_addr = ptr;
                    ptr_next = dec;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== hdl/lsm_core.sv ====
// Contract
// RULE_01 - dest bit 0 accumulator, 1 file
// RULE_02 - or with file, zero flag only
// RULE_03 - left shift: bit7 to carry, zero in
// RULE_04 - right shift: bit0 to carry, zero in
// RULE_05 - move file, zero flag, one cycle
// RULE_06 - indirect load via selected pointer, zero flag
// RULE_07 - update code: pre/post increment/decrement
// RULE_08 - relative offset -32..31, pointer unchanged
// RULE_09 - indirect ports redirect to pointer address
// RULE_10 - 16-bit pointers wrap at both ends
// RULE_11 - pointer adjust never touches flags
// RULE_12 - zero flag set when result zero
`timescale 1ns/1ps
`default_nettype none
module lsm_core
    import lsm_pkg::*;
(
    input  wire logic         sys_clk,     // 200 MHz core clock
    input  wire logic         rst_n,       // async, active low
    input  wire lsm_instr_t   instr,       // instruction, one per cycle
    input  wire logic         instr_vld,   // instruction valid
    input  wire logic [7:0]   file_rdata,  // direct file register read data
    input  wire logic [7:0]   mem_rdata,   // data memory read data (same cycle)
    input  wire logic         ptr_wr,      // core writes a pointer
    input  wire logic         ptr_wsel,    // which pointer
    input  wire logic [15:0]  ptr_wdata,   // pointer write value
    output logic [6:0]        file_raddr,  // direct file read address
    output lsm_mem_req_t      mem_req,     // data memory request (combinational read)
    output logic [7:0]        file_wdata,  // registered file write data
    output logic [6:0]        file_waddr,  // registered file write address
    output logic              file_we,     // registered file write strobe
    output logic [7:0]        mem_wdata_q, // registered indirect write data
    output logic [15:0]       mem_waddr_q, // registered indirect write address
    output logic              mem_we_q,    // registered indirect write strobe
    output logic [7:0]        acc,         // accumulator
    output lsm_flags_t        flags,       // carry and zero
    output logic [15:0]       ptr0,        // pointer 0
    output logic [15:0]       ptr1         // pointer 1
);

    // ==========================================================
    // helpers
    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);                                 // RULE_12
    endfunction

    function automatic logic is_ind_port(input logic [6:0] a);
        return (a == LSM_FADDR_IND0) || (a == LSM_FADDR_IND1);
    endfunction

    // ==========================================================
    // state
    logic [7:0]  acc_q, acc_d;       // accumulator
    lsm_flags_t  flg_q, flg_d;       // status flags
    logic [15:0] ptr_q [2];          // pointer_register pair
    logic [15:0] ptr_d [2];
    logic [7:0]  fwd_q, fwd_d;       // file write data
    logic [6:0]  fwa_q, fwa_d;       // file write address
    logic        fwe_q, fwe_d;       // file write strobe
    logic [7:0]  mwd_q, mwd_d;       // indirect write data
    logic [15:0] mwa_q, mwa_d;       // indirect write address
    logic        mwe_q, mwe_d;       // indirect write strobe

    // ==========================================================
    // pointer arithmetic for the selected pointer
    logic [15:0] ptr_sel;            // selected pointer
    logic [15:0] eff_addr;           // access address
    logic [15:0] ptr_next;           // adjusted pointer
    logic        ind_op;             // indirect load this cycle
    logic        redirect;           // direct op naming an indirect port
    logic [15:0] redir_addr;         // pointer behind that port
    logic [7:0]  src;                // operand after redirection
    logic [7:0]  res;                // 8-bit result
    logic        carry_new;          // shifted-out bit

    assign ind_op     = instr_vld && (instr.op == LSM_OP_IND || instr.op == LSM_OP_REL);
    assign ptr_sel    = ptr_q[instr.psel];
    // port address bit 0 picks the pointer
    assign redirect   = instr_vld && !ind_op && instr.op != LSM_OP_NONE
                        && is_ind_port(instr.faddr);         // RULE_09
    assign redir_addr = ptr_q[instr.faddr[0]];               // RULE_09

    lsm_ptr_unit u_ptr (
        .ptr      (ptr_sel),
        .rel      (instr.op == LSM_OP_REL),
        .upd      (instr.upd),
        .offs     (instr.offs),
        .eff_addr (eff_addr),
        .ptr_next (ptr_next)
    );

    // ==========================================================
    // read ports, combinational so the op finishes in one cycle
    always_comb begin
        file_raddr    = instr.faddr;
        mem_req.rd    = ind_op || redirect;                  // RULE_06
        mem_req.wr    = 1'b0;                                // writes go via the _q port
        mem_req.addr  = ind_op ? eff_addr : redir_addr;
        mem_req.wdata = 8'h00;
        src           = redirect ? mem_rdata : file_rdata;   // RULE_09
    end

    // ==========================================================
    // datapath and next state
    always_comb begin
        acc_d     = acc_q;
        flg_d     = flg_q;
        ptr_d[0]  = ptr_q[0];
        ptr_d[1]  = ptr_q[1];
        fwd_d     = fwd_q;
        fwa_d     = fwa_q;
        fwe_d     = 1'b0;
        mwd_d     = mwd_q;
        mwa_d     = mwa_q;
        mwe_d     = 1'b0;
        res       = 8'h00;
        carry_new = flg_q.carry;
        // pointer load from the core; an instruction update wins below
        if (ptr_wr) begin
            ptr_d[ptr_wsel] = ptr_wdata;
        end
        if (instr_vld) begin
            unique case (instr.op)
                LSM_OP_NONE: begin
                    res = 8'h00;                             // idle
                end
                LSM_OP_OR: begin
                    res = acc_q | src;                       // RULE_02
                end
                LSM_OP_LSL: begin
                    res       = {src[6:0], 1'b0};            // RULE_03
                    carry_new = src[7];                      // RULE_03
                end
                LSM_OP_LSR: begin
                    res       = {1'b0, src[7:1]};            // RULE_04
                    carry_new = src[0];                      // RULE_04
                end
                LSM_OP_MOV: begin
                    res = src;                               // RULE_05
                end
                LSM_OP_IND, LSM_OP_REL: begin
                    res              = mem_rdata;            // RULE_06
                    acc_d            = mem_rdata;            // RULE_06
                    ptr_d[instr.psel] = ptr_next;            // RULE_07
                    flg_d.zero       = is_zero(mem_rdata);   // RULE_06
                end
                default: begin
                    res = 8'h00;                             // unused code: no effect
                end
            endcase
            // direct file-register operations
            if (instr.op inside {LSM_OP_OR, LSM_OP_LSL, LSM_OP_LSR, LSM_OP_MOV}) begin
                flg_d.zero = is_zero(res);                   // RULE_12
                if (instr.op == LSM_OP_LSL || instr.op == LSM_OP_LSR) begin
                    flg_d.carry = carry_new;                 // RULE_03
                end
                if (!instr.dest) begin
                    acc_d = res;                             // RULE_01
                end else if (redirect) begin
                    mwd_d = res;                             // RULE_09
                    mwa_d = redir_addr;
                    mwe_d = 1'b1;
                end else begin
                    fwd_d = res;                             // RULE_01
                    fwa_d = instr.faddr;
                    fwe_d = 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // registers only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q    <= LSM_ACC_RST;
            flg_q    <= '0;
            ptr_q[0] <= LSM_PTR_RST;
            ptr_q[1] <= LSM_PTR_RST;
            fwd_q    <= 8'h00;
            fwa_q    <= 7'h00;
            fwe_q    <= 1'b0;
            mwd_q    <= 8'h00;
            mwa_q    <= 16'h0000;
            mwe_q    <= 1'b0;
        end else begin
            acc_q    <= acc_d;
            flg_q    <= flg_d;
            ptr_q[0] <= ptr_d[0];
            ptr_q[1] <= ptr_d[1];
            fwd_q    <= fwd_d;
            fwa_q    <= fwa_d;
            fwe_q    <= fwe_d;
            mwd_q    <= mwd_d;
            mwa_q    <= mwa_d;
            mwe_q    <= mwe_d;
        end
    end

    // outputs straight from flops (mem_req/file_raddr are read-address paths)
    assign acc         = acc_q;
    assign flags       = flg_q;
    assign ptr0        = ptr_q[0];
    assign ptr1        = ptr_q[1];
    assign file_wdata  = fwd_q;
    assign file_waddr  = fwa_q;
    assign file_we     = fwe_q;
    assign mem_wdata_q = mwd_q;
    assign mem_waddr_q = mwa_q;
    assign mem_we_q    = mwe_q;

    // ==========================================================
    // checks
    // the result properties look one edge after the op, once the registered
    // results stand; the read-address ones check in the op's own cycle;
    // direct ops on an indirect port read memory, not file data, so the
    // direct group leaves them to the port group and the bench walks
    // pointer 1 through both of its wrap points

    // direct file operations
    or_result_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_02
        instr_vld && instr.op == LSM_OP_OR && !instr.dest && !redirect
        |=> acc == ($past(acc) | $past(file_rdata)) && flags.carry == $past(flags.carry))
        else $error("or result wrong");
    dest_file_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_01
        instr_vld && instr.op == LSM_OP_MOV && instr.dest && !redirect
        |=> file_we && file_wdata == $past(file_rdata) && acc == $past(acc))
        else $error("move to file wrong");
    shl_carry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_03
        instr_vld && instr.op == LSM_OP_LSL && !redirect
        |=> flags.carry == $past(file_rdata[7]))
        else $error("left shift carry wrong");
    lsl_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_03
        instr_vld && instr.op == LSM_OP_LSL && !instr.dest && !redirect
        |=> acc == {$past(file_rdata[6:0]), 1'b0} && flags.zero == ($past(file_rdata[6:0]) == 7'h00))
        else $error("left shift value wrong");
    shr_value_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_04
        instr_vld && instr.op == LSM_OP_LSR && !instr.dest && !redirect
        |=> acc == {1'b0, $past(file_rdata[7:1])} && flags.carry == $past(file_rdata[0]))
        else $error("right shift wrong");
    zero_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_12
        instr_vld && instr.op == LSM_OP_MOV && !instr.dest && !redirect
        |=> flags.zero == (acc == 8'h00))
        else $error("zero flag wrong");

    // write strobes only follow an op; a stray strobe would corrupt
    // a file register or memory byte the core never meant to touch
    idle_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_01
        !instr_vld |=> !file_we && !mem_we_q)
        else $error("write without an op");

    // pointer adjust and indirect load; sums are cut to 16 bits by
    // the compare width, which is exactly the wrap the pointers need
    ind_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_06
        ind_op |=> acc == $past(mem_rdata) && flags.zero == ($past(mem_rdata) == 8'h00))
        else $error("indirect load wrong");
    pre_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_07
        instr_vld && instr.op == LSM_OP_IND && instr.upd == LSM_UPD_PRE_INC && !instr.psel
        |-> mem_req.addr == ptr0 + 16'h0001 ##1 ptr0 == $past(ptr0) + 16'h0001)
        else $error("pre-increment wrong");
    pre_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_07
        instr_vld && instr.op == LSM_OP_IND && instr.upd == LSM_UPD_PRE_DEC && instr.psel
        |-> mem_req.addr == ptr1 - 16'h0001 ##1 ptr1 == $past(ptr1) - 16'h0001)
        else $error("pre-decrement wrong");
    post_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_07
        instr_vld && instr.op == LSM_OP_IND && instr.upd == LSM_UPD_POST_INC && instr.psel
        |-> mem_req.addr == ptr1 ##1 ptr1 == $past(ptr1) + 16'h0001)
        else $error("post-increment wrong");
    post_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_10
        instr_vld && instr.op == LSM_OP_IND && instr.upd == LSM_UPD_POST_DEC && instr.psel
        |-> mem_req.addr == ptr1 ##1 ptr1 == $past(ptr1) - 16'h0001)
        else $error("post-decrement wrong");
    rel_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_08
        instr_vld && instr.op == LSM_OP_REL && !instr.psel
        |-> mem_req.addr == ptr0 + {{10{instr.offs[5]}}, instr.offs})
        else $error("relative address wrong");
    rel_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_08
        instr_vld && instr.op == LSM_OP_REL && !instr.psel && !ptr_wr
        |=> ptr0 == $past(ptr0))
        else $error("relative form moved pointer");
    ptr_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_11
        ind_op |=> flags.carry == $past(flags.carry))
        else $error("pointer adjust changed carry");
    ptr_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_10
        ptr_wr && !ind_op
        |=> ($past(ptr_wsel) ? ptr1 : ptr0) == $past(ptr_wdata))
        else $error("pointer load lost");

    // indirect ports: redirected to the pointer, pointer left alone,
    // so a port access can never double as a hidden pointer step
    port_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_09
        instr_vld && instr.op inside {LSM_OP_OR, LSM_OP_LSL, LSM_OP_LSR, LSM_OP_MOV} && is_ind_port(instr.faddr)
        |-> mem_req.rd && mem_req.addr == (instr.faddr[0] ? ptr1 : ptr0))
        else $error("port read misdirected");
    port_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_09
        instr_vld && instr.op == LSM_OP_MOV && instr.dest && is_ind_port(instr.faddr)
        |=> mem_we_q && !file_we && mem_waddr_q == $past(mem_req.addr) && mem_wdata_q == $past(mem_rdata))
        else $error("port write misdirected");
    port_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)  // RULE_09
        instr_vld && instr.op inside {LSM_OP_OR, LSM_OP_LSL, LSM_OP_LSR, LSM_OP_MOV} && is_ind_port(instr.faddr)
        && !ptr_wr |=> ptr0 == $past(ptr0) && ptr1 == $past(ptr1))
        else $error("port access moved pointer");

endmodule
`default_nettype wire

// ==== verif/lsm_core_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsm_core_tb_top;
    import lsm_pkg::*;
    // ==========================================================
    // signals
    logic         sys_clk;     // 200 MHz clock
    logic         rst_n;       // active low reset
    lsm_instr_t   instr;       // instruction under test
    logic         instr_vld;   // instruction valid
    logic [7:0]   file_rdata;  // file data driven per op
    logic [7:0]   mem_rdata;   // data memory answer
    logic         ptr_wr;      // pointer load strobe
    logic         ptr_wsel;    // pointer select
    logic [15:0]  ptr_wdata;   // pointer load value
    logic [6:0]   file_raddr;
    lsm_mem_req_t mem_req;
    logic [7:0]   file_wdata;
    logic [6:0]   file_waddr;
    logic         file_we;
    logic [7:0]   mem_wdata_q;
    logic [15:0]  mem_waddr_q;
    logic         mem_we_q;
    logic [7:0]   acc;
    lsm_flags_t   flags;
    logic [15:0]  ptr0;
    logic [15:0]  ptr1;
    int           failures;    // mismatch count
    int           num_checks;  // comparison count

    always #2.5 sys_clk = ~sys_clk;
    // memory model: data is low address byte plus one, so 0xFFFF reads zero
    assign mem_rdata = mem_req.addr[7:0] + 8'h01;

    lsm_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr), .instr_vld(instr_vld),
        .file_rdata(file_rdata), .mem_rdata(mem_rdata), .ptr_wr(ptr_wr), .ptr_wsel(ptr_wsel),
        .ptr_wdata(ptr_wdata), .file_raddr(file_raddr), .mem_req(mem_req), .file_wdata(file_wdata),
        .file_waddr(file_waddr), .file_we(file_we), .mem_wdata_q(mem_wdata_q),
        .mem_waddr_q(mem_waddr_q), .mem_we_q(mem_we_q), .acc(acc), .flags(flags),
        .ptr0(ptr0), .ptr1(ptr1));

    // ==========================================================
    // helpers
    function automatic logic [7:0] md(input logic [15:0] a);
        md = a[7:0] + 8'h01;   // same memory map as the model above
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one instruction; read request checked while it is presented
    task automatic run(input lsm_op_t op, input logic d, input logic [6:0] fa, input logic ps,
                       input logic [1:0] up, input logic [5:0] of, input logic [7:0] fd,
                       input logic xrd, input logic [15:0] xaddr);
        @(posedge sys_clk);
        #1;
        instr      = '{op: op, dest: d, faddr: fa, psel: ps, upd: up, offs: of};
        instr_vld  = 1'h1;
        file_rdata = fd;
        #1;
        chk(mem_req.rd, xrd);
        chk({mem_req.wr, mem_req.wdata}, 9'h000);
        chk(file_raddr, fa);
        if (xrd) begin
            chk(mem_req.addr, xaddr);
        end
        @(posedge sys_clk);
        #1;
        instr_vld = 1'h0;
    endtask

    task automatic pw(input logic s, input logic [15:0] v);
        @(posedge sys_clk);
        #1;
        ptr_wr    = 1'h1;
        ptr_wsel  = s;
        ptr_wdata = v;
        @(posedge sys_clk);
        #1;
        ptr_wr = 1'h0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_or_mov;
        run(LSM_OP_MOV, 1'h0, 7'h05, 1'h0, 2'h0, 6'h00, 8'h5A, 1'h0, 16'h0000);
        chk(acc, 8'h5A);
        chk(file_we, 1'h0);
        chk({flags.carry, flags.zero}, 2'h0);
        run(LSM_OP_MOV, 1'h1, 7'h0C, 1'h0, 2'h0, 6'h00, 8'h00, 1'h0, 16'h0000);
        chk({file_we, file_waddr, file_wdata, acc, flags.zero}, {1'h1, 7'h0C, 8'h00, 8'h5A, 1'h1});
        run(LSM_OP_OR, 1'h1, 7'h10, 1'h0, 2'h0, 6'h00, 8'h03, 1'h0, 16'h0000);
        chk(file_we, 1'h1);
        chk({file_waddr, file_wdata}, {7'h10, 8'h5B});
        chk(acc, 8'h5A);
        @(posedge sys_clk);
        #1;
        chk(file_we, 1'h0);
        run(LSM_OP_MOV, 1'h0, 7'h06, 1'h0, 2'h0, 6'h00, 8'h00, 1'h0, 16'h0000);
        chk({acc, flags.zero}, {8'h00, 1'h1});
        run(LSM_OP_OR, 1'h0, 7'h07, 1'h0, 2'h0, 6'h00, 8'h80, 1'h0, 16'h0000);
        chk({acc, flags.carry, flags.zero}, {8'h80, 2'h0});
        // idle and undefined codes leave state alone
        run(LSM_OP_NONE, 1'h1, 7'h07, 1'h0, 2'h0, 6'h00, 8'h00, 1'h0, 16'h0000);
        chk({acc, file_we}, {8'h80, 1'h0});
        run(lsm_op_t'(3'h7), 1'h1, 7'h07, 1'h0, 2'h0, 6'h00, 8'h00, 1'h0, 16'h0000);
        chk({acc, file_we}, {8'h80, 1'h0});
    endtask

    task automatic sh(input lsm_op_t op, input logic [7:0] fd, input logic [7:0] xr, input logic [1:0] xf);
        run(op, 1'h0, 7'h08, 1'h0, 2'h0, 6'h00, fd, 1'h0, 16'h0000);
        chk({acc, flags.carry, flags.zero}, {xr, xf});
    endtask

    task automatic t_shift;
        sh(LSM_OP_LSL, 8'h81, 8'h02, 2'h2);
        sh(LSM_OP_LSL, 8'h80, 8'h00, 2'h3);
        sh(LSM_OP_LSL, 8'h7F, 8'hFE, 2'h0);
        sh(LSM_OP_LSR, 8'h01, 8'h00, 2'h3);
        sh(LSM_OP_LSR, 8'h82, 8'h41, 2'h0);
        sh(LSM_OP_LSR, 8'hFE, 8'h7F, 2'h0);
        run(LSM_OP_LSL, 1'h1, 7'h09, 1'h0, 2'h0, 6'h00, 8'hC0, 1'h0, 16'h0000);
        chk({file_we, file_wdata, acc}, {1'h1, 8'h80, 8'h7F});
        chk({flags.carry, flags.zero}, 2'h2);
    endtask

    task automatic t_ind_upd;
        logic [15:0] xa [4];
        logic [15:0] xp [4];
        xa = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
        xp = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
        sh(LSM_OP_LSL, 8'h80, 8'h00, 2'h3);    // carry held high across pointer moves
        pw(1'h1, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            run(LSM_OP_IND, 1'h0, 7'h00, 1'h1, i[1:0], 6'h00, 8'h00, 1'h1, xa[i]);
            chk(ptr1, xp[i]);
            chk(ptr0, 16'h0000);
            chk(acc, md(xa[i]));
            chk(flags.zero, md(xa[i]) == 8'h00);
            chk(flags.carry, 1'h1);
        end
    endtask

    task automatic t_ind_rel;
        logic [5:0]  of [3];
        logic [15:0] xa [3];
        of = '{6'h20, 6'h1F, 6'h00};
        xa = '{16'h0FE0, 16'h101F, 16'h1000};
        // pointer 0 still at reset value: one pre-increment before the load
        run(LSM_OP_IND, 1'h0, 7'h00, 1'h0, LSM_UPD_PRE_INC, 6'h00, 8'h00, 1'h1, 16'h0001);
        chk({ptr0, acc}, {16'h0001, md(16'h0001)});
        pw(1'h0, 16'h1000);
        for (int i = 0; i < 3; i++) begin
            run(LSM_OP_REL, 1'h0, 7'h00, 1'h0, 2'h0, of[i], 8'h00, 1'h1, xa[i]);
            chk(ptr0, 16'h1000);
            chk(acc, md(xa[i]));
        end
    endtask

    task automatic t_port;
        run(LSM_OP_MOV, 1'h0, LSM_FADDR_IND1, 1'h0, 2'h0, 6'h00, 8'h55, 1'h1, 16'hFFFF);
        chk({acc, flags.zero}, {8'h00, 1'h1});
        run(LSM_OP_MOV, 1'h1, LSM_FADDR_IND0, 1'h0, 2'h0, 6'h00, 8'h55, 1'h1, 16'h1000);
        chk(mem_we_q, 1'h1);
        chk({mem_waddr_q, mem_wdata_q}, {16'h1000, 8'h01});
        chk({ptr0, ptr1}, {16'h1000, 16'hFFFF});
        run(LSM_OP_OR, 1'h0, LSM_FADDR_IND0, 1'h0, 2'h0, 6'h00, 8'h80, 1'h1, 16'h1000);
        chk({acc, mem_we_q}, {8'h01, 1'h0});
    endtask

    // ==========================================================
    // main sequence; a watchdog guards against a stalled run
    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    initial begin
        sys_clk    = 1'h0;
        rst_n      = 1'h0;
        instr      = '0;
        instr_vld  = 1'h0;
        file_rdata = 8'h00;
        ptr_wr     = 1'h0;
        ptr_wsel   = 1'h0;
        ptr_wdata  = 16'h0000;
        failures   = 0;
        num_checks = 0;
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'h1;
        chk({acc, flags.carry, flags.zero}, 10'h000);
        chk({ptr0, ptr1}, 32'h0);
        chk({file_we, mem_we_q}, 2'h0);
        t_or_mov();
        t_shift();
        t_ind_upd();
        t_ind_rel();
        t_port();
        wrap_up();
    end
endmodule
`default_nettype wire
